//--- pkg/gtc_pkg.sv
/*
 * gtc_pkg: register map, field positions, reset values and mode codes
 * shared by the gated 16-bit timer/counter and its bench.
 * assumes a 32-bit apb bus with byte addresses and one register per word.
 */
`default_nettype none

package gtc_pkg;

	// register byte offsets
	localparam logic [7:0] GTC_OFF_TIMER_CTRL = 8'h00;
	localparam logic [7:0] GTC_OFF_GATE_CTRL = 8'h04;
	localparam logic [7:0] GTC_OFF_COUNT_LOW = 8'h08;
	localparam logic [7:0] GTC_OFF_COUNT_HIGH = 8'h0c;
	localparam logic [7:0] GTC_OFF_STATUS = 8'h10;

	// timer_control_reg fields
	localparam int GTC_TC_ON_BIT = 0;
	localparam int GTC_TC_SYNC_DIS_BIT = 2;
	localparam int GTC_TC_PS_LSB = 4;
	localparam int GTC_TC_CS_LSB = 6;

	// gate_control_reg fields
	localparam int GTC_GC_GSS_LSB = 0;
	localparam int GTC_GC_POL_BIT = 6;
	localparam int GTC_GC_GE_BIT = 7;

	// status register fields
	localparam int GTC_ST_OVF_BIT = 0;
	localparam int GTC_ST_GATE_BIT = 1;
	localparam int GTC_ST_ARMED_BIT = 2;

	// reset values
	localparam logic [15:0] GTC_COUNT_RST = 16'h0000;
	localparam logic [2:0] GTC_PRESC_RST = 3'h0;
	localparam logic [7:0] GTC_CTRL_RST = 8'h00;

	// timing counts
	localparam int GTC_INSTR_DIV = 4;
	localparam logic [7:0] GTC_T0_MAX = 8'hff;
	localparam logic [7:0] GTC_T0_MIN = 8'h00;

	// clock source codes
	typedef enum logic [1:0] {
		GTC_CS_INSTR = 2'h0,
		GTC_CS_SYSTEM = 2'h1,
		GTC_CS_EXT_PIN = 2'h2,
		GTC_CS_LF_OSC = 2'h3
	} gtc_clk_src_type;

	// gate source codes
	typedef enum logic [1:0] {
		GTC_GS_PIN = 2'h0,
		GTC_GS_T0_OVF = 2'h1,
		GTC_GS_CMP_A = 2'h2,
		GTC_GS_CMP_B = 2'h3
	} gtc_gate_src_type;

endpackage

`default_nettype wire

//--- rtl/gtc_timer.sv
/*
 * gtc_timer: gated 16-bit up-counter with four clock sources, a 1/2/4/8
 * prescaler, synchronous or unsynchronised external counting and a
 * four-source count-enable gate, with apb register access.
 * assumes one 125 MHz clock; pins and the slow oscillator arrive
 * asynchronously; comparator outputs and the 8-bit timer value come from
 * logic on the same clock.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
// Notes on behaviour
// - sixteen-bit up-counter, byte writes act at once
// - on bit off stops; gate matters when enabled
// - clock source codes instr, system, pin, oscillator
// - internal sources advance once per prescaled period
// - prescaler divides by one, two, four, eight
// - prescaler hidden; cleared by count byte writes
// - external pin counts on rising edges
// - falling pin edge needed before first count
// - oscillator source forces oscillator on, sleep too
// - unsynchronised external counting runs and wakes in sleep
// - mode switch may drop or add one count
// - count byte reads always return valid value
// - gate active counts, inactive holds count
// - one polarity bit applies to every gate source
// - gate source codes pin, t0 overflow, comparators
// - eight-bit timer wrap gives internal gate pulse
// - rollover sets overflow flag, software clears it
// - sync disable ignored for internal sources
// - prescale codes map to one, two, four, eight
`default_nettype none

module gtc_timer
	import gtc_pkg::*;
#(
	parameter int INSTR_DIV = GTC_INSTR_DIV
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clock_pin,
	input wire logic gate_pin,
	input wire logic low_freq_internal_osc,
	input wire logic sleep_req,
	input wire logic comparator_a_sync_out,
	input wire logic comparator_b_sync_out,
	input wire logic [7:0] eight_bit_timer,
	output logic overflow_flag,
	output logic wake_pulse,
	output logic lf_osc_enable
);

	localparam int NUM_SYNC = 4;
	localparam int IDIV_W = $clog2(INSTR_DIV);

	// elaboration check: the instruction clock needs a real divider
	if (INSTR_DIV < 2 || INSTR_DIV > 256) begin : g_bad_div
		$error("gtc_timer: INSTR_DIV out of range");
	end

	// address decode used by the error path only; read and write decode paddr directly
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == GTC_OFF_TIMER_CTRL) || (a == GTC_OFF_GATE_CTRL) || (a == GTC_OFF_COUNT_LOW) ||
			(a == GTC_OFF_COUNT_HIGH) || (a == GTC_OFF_STATUS);
	endfunction

	// last prescaler value for a prescale code: 0,1,3,7
	function automatic logic [2:0] presc_last(input logic [1:0] ps);
		presc_last = 3'((4'h1 << ps) - 4'h1);
	endfunction

	logic rst_meta_q, rst_sync_q;
	logic [NUM_SYNC-1:0] pin_async, sync1_q, sync2_q, prev_q;
	logic ext_s, gate_s, lf_s, sleep_s;
	logic ext_rise, ext_fall, lf_rise;
	logic on_q, sync_dis_q, ge_q, pol_q;
	logic [1:0] cs_q, ps_q, gss_q;
	logic [15:0] count_q;
	logic [2:0] presc_q;
	logic [IDIV_W-1:0] idiv_q;
	logic instr_tick;
	logic armed_q;
	logic [7:0] t0_prev_q;
	logic t0_wrap_q;
	logic gate_src, gate_active, run, src_tick, inc, ovf_event;
	logic acc_cycle, wr_fire, wr_count_low, wr_count_high, wr_count;
	logic ovf_clear;
	logic [31:0] rd_value;

	// reset release through two flip-flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// pin synchronisers; only the second stage and its delayed copy are read
	assign pin_async = {sleep_req, low_freq_internal_osc, gate_pin, ext_clock_pin};
	for (genvar i = 0; i < NUM_SYNC; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_sync_q) begin
			if (!rst_sync_q) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
				prev_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= pin_async[i];
				sync2_q[i] <= sync1_q[i];
				prev_q[i] <= sync2_q[i];
			end
		end
	end

	assign ext_s = sync2_q[0];
	assign gate_s = sync2_q[1];
	assign lf_s = sync2_q[2];
	assign sleep_s = sync2_q[3];
	assign ext_rise = ext_s && !prev_q[0];
	assign ext_fall = !ext_s && prev_q[0];
	assign lf_rise = lf_s && !prev_q[2];

	// apb: access phase waits one cycle so read data comes from a flop
	assign acc_cycle = psel && penable;
	assign wr_fire = acc_cycle && pready && pwrite;
	assign wr_count_low = wr_fire && (paddr == GTC_OFF_COUNT_LOW);
	assign wr_count_high = wr_fire && (paddr == GTC_OFF_COUNT_HIGH);
	assign wr_count = wr_count_low || wr_count_high;
	assign ovf_clear = wr_fire && (paddr == GTC_OFF_STATUS) && pwdata[GTC_ST_OVF_BIT];

	// read mux; each count byte is sampled at its own access, so the low and high bytes can tear
	always_comb begin
		rd_value = 32'h0000_0000;
		case (paddr)
			GTC_OFF_TIMER_CTRL: begin
				rd_value[GTC_TC_CS_LSB +: 2] = cs_q;
				rd_value[GTC_TC_PS_LSB +: 2] = ps_q;
				rd_value[GTC_TC_SYNC_DIS_BIT] = sync_dis_q;
				rd_value[GTC_TC_ON_BIT] = on_q;
			end
			GTC_OFF_GATE_CTRL: begin
				rd_value[GTC_GC_GE_BIT] = ge_q;
				rd_value[GTC_GC_POL_BIT] = pol_q;
				rd_value[GTC_GC_GSS_LSB +: 2] = gss_q;
			end
			GTC_OFF_COUNT_LOW: rd_value[7:0] = count_q[7:0];
			GTC_OFF_COUNT_HIGH: rd_value[7:0] = count_q[15:8];
			GTC_OFF_STATUS: begin
				rd_value[GTC_ST_OVF_BIT] = overflow_flag;
				rd_value[GTC_ST_GATE_BIT] = gate_active;
				rd_value[GTC_ST_ARMED_BIT] = armed_q;
			end
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// bus answer: pready rises on the second access cycle, for one cycle
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_cycle && !pready;
			if (acc_cycle && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_value;
				pslverr <= !addr_mapped(paddr);
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// control registers
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			on_q <= GTC_CTRL_RST[GTC_TC_ON_BIT];
			sync_dis_q <= GTC_CTRL_RST[GTC_TC_SYNC_DIS_BIT];
			ps_q <= GTC_CTRL_RST[GTC_TC_PS_LSB +: 2];
			cs_q <= GTC_CTRL_RST[GTC_TC_CS_LSB +: 2];
			ge_q <= GTC_CTRL_RST[GTC_GC_GE_BIT];
			pol_q <= GTC_CTRL_RST[GTC_GC_POL_BIT];
			gss_q <= GTC_CTRL_RST[GTC_GC_GSS_LSB +: 2];
		end else if (wr_fire && paddr == GTC_OFF_TIMER_CTRL) begin
			on_q <= pwdata[GTC_TC_ON_BIT];
			sync_dis_q <= pwdata[GTC_TC_SYNC_DIS_BIT];
			ps_q <= pwdata[GTC_TC_PS_LSB +: 2];
			cs_q <= pwdata[GTC_TC_CS_LSB +: 2];
		end else if (wr_fire && paddr == GTC_OFF_GATE_CTRL) begin
			ge_q <= pwdata[GTC_GC_GE_BIT];
			pol_q <= pwdata[GTC_GC_POL_BIT];
			gss_q <= pwdata[GTC_GC_GSS_LSB +: 2];
		end
	end

	// instruction clock enable: one pulse every INSTR_DIV system cycles
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			idiv_q <= '0;
		end else if (idiv_q == IDIV_W'(INSTR_DIV - 1)) begin
			idiv_q <= '0;
		end else begin
			idiv_q <= idiv_q + 1'b1;
		end
	end
	assign instr_tick = (idiv_q == IDIV_W'(INSTR_DIV - 1));

	// eight-bit timer wrap becomes a one-cycle internal gate pulse
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			t0_prev_q <= 8'h00;
			t0_wrap_q <= 1'b0;
		end else begin
			t0_prev_q <= eight_bit_timer;
			t0_wrap_q <= (t0_prev_q == GTC_T0_MAX) && (eight_bit_timer == GTC_T0_MIN);
		end
	end

	// gate source and polarity
	always_comb begin
		case (gtc_gate_src_type'(gss_q))
			GTC_GS_PIN: gate_src = gate_s;
			GTC_GS_T0_OVF: gate_src = t0_wrap_q;
			GTC_GS_CMP_A: gate_src = comparator_a_sync_out;
			GTC_GS_CMP_B: gate_src = comparator_b_sync_out;
			default: gate_src = gate_s;
		endcase
	end
	assign gate_active = pol_q ? gate_src : !gate_src;
	assign run = on_q && (!ge_q || gate_active);

	// clock source ticks; system and instruction clocks halt in sleep
	always_comb begin
		case (gtc_clk_src_type'(cs_q))
			GTC_CS_INSTR: src_tick = instr_tick && !sleep_s;
			GTC_CS_SYSTEM: src_tick = !sleep_s;
			GTC_CS_EXT_PIN: src_tick = ext_rise && armed_q && (sync_dis_q || !sleep_s);
			GTC_CS_LF_OSC: src_tick = lf_rise;
			default: src_tick = 1'b0;
		endcase
	end

	// a falling pin edge must be seen before the first rising edge counts
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			armed_q <= 1'b0;
		end else if (!on_q || wr_count) begin
			armed_q <= 1'b0;
		end else if (ext_fall) begin
			armed_q <= 1'b1;
		end
	end

	// prescaler: hidden from software, cleared by any count byte write
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			presc_q <= GTC_PRESC_RST;
		end else if (wr_count || !on_q) begin
			presc_q <= GTC_PRESC_RST;
		end else if (run && src_tick) begin
			presc_q <= (presc_q >= presc_last(ps_q)) ? GTC_PRESC_RST : presc_q + 3'h1;
		end
	end
	assign inc = run && src_tick && (presc_q >= presc_last(ps_q));
	assign ovf_event = inc && (count_q == 16'hffff);

	// counter; a byte write wins over a colliding increment
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			count_q <= GTC_COUNT_RST;
		end else if (wr_count_low) begin
			count_q[7:0] <= pwdata[7:0];
		end else if (wr_count_high) begin
			count_q[15:8] <= pwdata[7:0];
		end else if (inc) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// overflow flag: hardware set wins over a write-one clear
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			overflow_flag <= 1'b0;
		end else if (ovf_event) begin
			overflow_flag <= 1'b1;
		end else if (ovf_clear) begin
			overflow_flag <= 1'b0;
		end
	end

	// wake pulse on overflow during sleep; oscillator request follows source
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wake_pulse <= 1'b0;
			lf_osc_enable <= 1'b0;
		end else begin
			wake_pulse <= ovf_event && sleep_s;
			lf_osc_enable <= (cs_q == GTC_CS_LF_OSC);
		end
	end

	// mode switches between synchronous and unsynchronised counting reuse
	// the same edge path, so at most one increment is gained or lost

endmodule

`default_nettype wire

//--- tb/gtc_far.sv
/*
 * gtc_far: pin-side model for the gated timer: free 8-bit timer, pin clock and slow clock.
 * assumes the bench opens a pin clock frame through ext_en.
 */
`default_nettype none

module gtc_far (
	input wire logic clk,
	input wire logic ext_en,
	output logic ext_clock_pin,
	output logic low_freq_internal_osc,
	output logic [7:0] eight_bit_timer
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] t0_q = 8'h00;

	// free-running timer; each ff to 00 wrap is a gate pulse
	always_ff @(posedge clk) begin
		t0_q <= t0_q + 8'h01;
	end

	// pin clock stands low outside a frame so no stray edge reaches the counter
	assign ext_clock_pin = ext_en & t0_q[2];
	assign low_freq_internal_osc = t0_q[4]; // slow clock, period 32 cycles
	assign eight_bit_timer = t0_q;
endmodule

`default_nettype wire

//--- tb/gtc_timer_asserts.sv
/*
 * gtc_timer_asserts: port-level properties of the gated timer.
 * assumes the bind below and one wait state on every apb access.
 */
`default_nettype none

module gtc_timer_asserts
	import gtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic overflow_flag,
	input wire logic wake_pulse,
	input wire logic lf_osc_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// access phase steps and the flag clear write
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_fin;
		psel && penable && pready;
	endsequence
	sequence s_clr;
		pready && pwrite && paddr == GTC_OFF_STATUS && pwdata[GTC_ST_OVF_BIT];
	endsequence

	a_ready_wait: assert property (s_wait |=> s_fin) else $error("no answer after wait state");
	a_ready_pulse: assert property (pready |=> !pready) else $error("answer longer than one cycle");
	a_ready_idle: assert property (!penable |-> !pready && !pslverr) else $error("answer outside access");
	a_err_decode: assert property (pready |-> pslverr == (paddr > GTC_OFF_STATUS || paddr[1:0] != 2'h0))
		else $error("bad error flag");
	a_rdata_zero: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("stray read data");
	a_osc_follow: assert property (pready && pwrite && paddr == GTC_OFF_TIMER_CTRL |=> ##1
		lf_osc_enable == (($past(pwdata, 2) & 32'hc0) == 32'hc0)) else $error("slow clock enable wrong");
	a_ovf_hold: assert property (overflow_flag && !(pready && pwrite && paddr == GTC_OFF_STATUS && pwdata[0])
		|=> overflow_flag) else $error("overflow flag lost");
	a_ovf_clear: assert property (s_clr |=> !overflow_flag) else $error("overflow flag not cleared");
	a_wake_once: assert property (wake_pulse |=> !wake_pulse && overflow_flag) else $error("bad wake pulse");
	a_reset_quiet: assert property ($rose(rst_b) |-> !overflow_flag && !wake_pulse && !lf_osc_enable)
		else $error("output set after reset");
endmodule

bind gtc_timer gtc_timer_asserts u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.overflow_flag(overflow_flag), .wake_pulse(wake_pulse), .lf_osc_enable(lf_osc_enable));

`default_nettype wire

//--- tb/gtc_timer_tb.sv
/*
 * gtc_timer_tb: reset case, then row table of count windows, then overflow, unmapped and sleep cases.
 * assumes the pin-side model and the bound checker.
 */
`default_nettype none

module gtc_timer_tb
	import gtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] tc, gc; logic g, s; int d; logic [15:0] lo, hi;} gtc_row_type;
	logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic gate_pin = 1'h0, sleep_req = 1'h0, ext_en = 1'h0, w = 1'h0;
	logic [7:0] paddr = 8'h00, t0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, overflow_flag, wake_pulse, lf_osc_enable, ext_clock_pin, osc, er;
	logic [15:0] cnt;
	int n_fail = 0, compares = 0, cyc = 0;
	// window of d+4 cycles between start and stop writes
	gtc_row_type rows[18] = '{'{8'h41, 8'h00, 0, 0, 16, 16'h14, 16'h14}, '{8'h51, 8'h00, 0, 0, 16, 16'ha, 16'ha},
		'{8'h61, 8'h00, 0, 0, 16, 16'h5, 16'h5}, '{8'h71, 8'h00, 0, 0, 16, 16'h2, 16'h2},
		'{8'h01, 8'h00, 0, 0, 16, 16'h4, 16'h6}, '{8'h45, 8'h00, 0, 0, 16, 16'h14, 16'h14},
		'{8'h41, 8'h80, 0, 0, 16, 16'h14, 16'h14}, '{8'h41, 8'h80, 1, 0, 16, 16'h0, 16'h0},
		'{8'h41, 8'hc0, 1, 0, 16, 16'h14, 16'h14}, '{8'h41, 8'hc3, 0, 0, 16, 16'h0, 16'h0},
		'{8'h41, 8'hc2, 1, 0, 16, 16'h14, 16'h14}, '{8'h41, 8'hc1, 0, 0, 516, 16'h1, 16'h3},
		'{8'h40, 8'h80, 0, 0, 16, 16'h0, 16'h0}, '{8'h81, 8'h00, 0, 0, 76, 16'h8, 16'ha},
		'{8'h85, 8'h00, 0, 1, 76, 16'h8, 16'ha}, '{8'h81, 8'h00, 0, 1, 76, 16'h0, 16'h0},
		'{8'h41, 8'h00, 0, 1, 16, 16'h0, 16'h0}, '{8'hc1, 8'h00, 0, 1, 76, 16'h1, 16'h3}};

	gtc_timer u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
		.gate_pin(gate_pin), .low_freq_internal_osc(osc), .sleep_req(sleep_req),
		.comparator_a_sync_out(gate_pin), .comparator_b_sync_out(gate_pin), .eight_bit_timer(t0),
		.overflow_flag(overflow_flag), .wake_pulse(wake_pulse), .lf_osc_enable(lf_osc_enable));
	gtc_far u_far (.clk(clk), .ext_en(ext_en), .ext_clock_pin(ext_clock_pin), .low_freq_internal_osc(osc),
		.eight_bit_timer(t0));

	// 125 MHz clock and a hang limit well above the expected run
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			close_out;
		end
	end

	// the master waits for pready as long as it takes; only the cycle limit ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdcnt;
		apb(1'h0, GTC_OFF_COUNT_LOW, 32'h0);
		cnt[7:0] = rd[7:0];
		apb(1'h0, GTC_OFF_COUNT_HIGH, 32'h0);
		cnt[15:8] = rd[7:0];
	endtask

	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rng(input logic [15:0] got, lo, hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'h1) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h to %h", $time, got, lo, hi);
		end
	endtask

	task automatic close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		apb(1'h0, GTC_OFF_TIMER_CTRL, 32'h0);
		chk(rd, 32'h0);
		rdcnt;
		chk(32'(cnt), 32'h0);
		$display("reset done");
		// each row: load zero, configure, run a window, stop, read back
		for (int i = 0; i < 18; i++) begin
			gate_pin <= rows[i].g;
			sleep_req <= rows[i].s;
			ext_en <= rows[i].tc[7:6] == 2'h2;
			apb(1'h1, GTC_OFF_COUNT_LOW, 32'h0);
			apb(1'h1, GTC_OFF_COUNT_HIGH, 32'h0);
			apb(1'h1, GTC_OFF_GATE_CTRL, {24'h0, rows[i].gc});
			apb(1'h1, GTC_OFF_TIMER_CTRL, {24'h0, rows[i].tc});
			repeat (rows[i].d) @(posedge clk);
			apb(1'h1, GTC_OFF_TIMER_CTRL, 32'h0);
			rdcnt;
			rng(cnt, rows[i].lo, rows[i].hi);
			$display("row %0d done", i);
		end
		// rollover sets a sticky flag that a write of one clears
		sleep_req <= 1'h0;
		ext_en <= 1'h0;
		apb(1'h1, GTC_OFF_GATE_CTRL, 32'h0);
		apb(1'h1, GTC_OFF_COUNT_LOW, 32'hfe);
		apb(1'h1, GTC_OFF_COUNT_HIGH, 32'hff);
		apb(1'h1, GTC_OFF_TIMER_CTRL, 32'h41);
		apb(1'h1, GTC_OFF_TIMER_CTRL, 32'h0);
		rdcnt;
		chk(32'(cnt), 32'h2);
		apb(1'h0, GTC_OFF_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		apb(1'h1, GTC_OFF_STATUS, 32'h1);
		// the clear lands on the edge that ends the write; look one edge later
		@(posedge clk);
		chk(32'(overflow_flag), 32'h0);
		$display("overflow done");
		// unmapped place answers with an error and zero data
		apb(1'h0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		$display("unmapped done");
		// slow clock keeps counting in sleep and its rollover wakes the device
		sleep_req <= 1'h1;
		apb(1'h1, GTC_OFF_COUNT_LOW, 32'hff);
		apb(1'h1, GTC_OFF_COUNT_HIGH, 32'hff);
		apb(1'h1, GTC_OFF_TIMER_CTRL, 32'hc1);
		for (int k = 0; k < 200 && !w; k++) begin
			@(posedge clk);
			w = wake_pulse;
		end
		chk(32'(w), 32'h1);
		// oscillator request is a level that settles a cycle after the source write
		chk(32'(lf_osc_enable), 32'h1);
		apb(1'h1, GTC_OFF_TIMER_CTRL, 32'h0);
		$display("sleep done");
		close_out;
	end
endmodule

`default_nettype wire
